// file: rtl/lsdr_cfg_core.sv
// Writable link direction and network fields plus the debug origin record.
`timescale 1ns/1ps
module lsdr_cfg_core (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic dbg_event,
    input wire logic [2:0] dbg_cause,
    lsdr_cfg_if.core cfg
);
    typedef struct packed {
        logic [lsdr_pkg::NUM_LINKS-1:0][3:0] dir;
        logic [lsdr_pkg::NUM_LINKS-1:0][1:0] net;
        logic [2:0] origin;
    } lsdr_core_state_t;

    lsdr_core_state_t state_reg;
    lsdr_core_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (cfg.wr_link) begin
            state_next.dir[cfg.wr_sel] = cfg.wr_data[lsdr_pkg::DIR_LSB +: 4];
            state_next.net[cfg.wr_sel] = cfg.wr_data[lsdr_pkg::NET_LSB +: 2];
        end
        if (cfg.wr_origin) begin
            state_next.origin = {cfg.wr_data[lsdr_pkg::ORIGIN_PIN_BIT],
                cfg.wr_data[lsdr_pkg::ORIGIN_CORE1_BIT], cfg.wr_data[lsdr_pkg::ORIGIN_CORE0_BIT]};
        end
        // A new debug event beats a software write in the same cycle.
        if (dbg_event) begin
            state_next.origin = dbg_cause;
        end
        if (!rst_n) begin
            state_next.origin = lsdr_pkg::ORIGIN_RESET;
            for (int i = 0; i < lsdr_pkg::NUM_LINKS; i++) begin
                state_next.dir[i] = lsdr_pkg::DIR_RESET;
                state_next.net[i] = lsdr_pkg::NET_RESET;
            end
        end
    end

    always_ff @(posedge clock) begin
        state_reg <= state_next;
    end

    always_comb begin
        for (int i = 0; i < lsdr_pkg::NUM_LINKS; i++) begin
            cfg.dir[i] = state_reg.dir[i];
            cfg.net[i] = state_reg.net[i];
        end
        cfg.origin = state_reg.origin;
    end

    a_origin_event: assert property (@(posedge clock) disable iff (!rst_n)
        dbg_event |=> state_reg.origin == $past(dbg_cause))
        else $error("debug origin not recorded");
    a_dir_write: assert property (@(posedge clock) disable iff (!rst_n)
        cfg.wr_link |=> state_reg.dir[$past(cfg.wr_sel)] == $past(cfg.wr_data[11:8]))
        else $error("direction write lost");
    a_net_write: assert property (@(posedge clock) disable iff (!rst_n)
        cfg.wr_link |=> state_reg.net[$past(cfg.wr_sel)] == $past(cfg.wr_data[5:4]))
        else $error("network write lost");
endmodule : lsdr_cfg_core

// file: rtl/lsdr_cfg_if.sv
// Interface carrying configuration writes from the bus slave to the register core and the field values back.
`timescale 1ns/1ps
interface lsdr_cfg_if;
    logic wr_link;
    logic [2:0] wr_sel;
    logic [31:0] wr_data;
    logic wr_origin;
    logic [3:0] dir [lsdr_pkg::NUM_LINKS];
    logic [1:0] net [lsdr_pkg::NUM_LINKS];
    logic [2:0] origin;
    modport slave (output wr_link, output wr_sel, output wr_data, output wr_origin,
        input dir, input net, input origin);
    modport core (input wr_link, input wr_sel, input wr_data, input wr_origin,
        output dir, output net, output origin);
endinterface : lsdr_cfg_if

// file: rtl/lsdr_link_status_regs.sv
// Top of the link status and debug register bank with its APB slave.
`timescale 1ns/1ps
module lsdr_link_status_regs (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dbg_event,
    input wire logic [2:0] dbg_cause,
    input wire logic [15:0] link_src_type,
    input wire logic [63:0] link_dest,
    input wire logic [7:0] link_junk,
    input wire logic [7:0] link_dest_use,
    input wire logic [7:0] link_src_use
);
    //------------------------------------------------------------------------
    // State
    //------------------------------------------------------------------------
    typedef struct packed {
        lsdr_pkg::lsdr_phase_t phase;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } lsdr_top_state_t;

    lsdr_top_state_t state_reg;
    lsdr_top_state_t state_next;
    lsdr_cfg_if cfg ();

    logic [9:0] word_idx;
    logic hit_origin;
    logic hit_link;
    logic [2:0] link_sel;
    logic setup_now;
    logic [31:0] read_word;

    //------------------------------------------------------------------------
    // Decode
    //------------------------------------------------------------------------
    // Printed offsets are word indices, so the byte address is four times the index.
    assign word_idx = paddr[11:2];
    assign hit_origin = (word_idx == {2'b00, lsdr_pkg::IDX_DEBUG_ORIGIN});
    assign hit_link = (word_idx[9:3] == {2'b00, lsdr_pkg::IDX_LINK_BASE[7:3]});
    assign link_sel = word_idx[2:0];
    assign setup_now = psel && !penable && (state_reg.phase == lsdr_pkg::LSDR_IDLE);

    always_comb begin
        read_word = 32'h0000_0000;
        if (hit_origin) begin
            read_word[lsdr_pkg::ORIGIN_PIN_BIT] = cfg.origin[2];
            read_word[lsdr_pkg::ORIGIN_CORE1_BIT] = cfg.origin[1];
            read_word[lsdr_pkg::ORIGIN_CORE0_BIT] = cfg.origin[0];
        end else if (hit_link) begin
            read_word = lsdr_pkg::lsdr_link_word(
                link_src_type[link_sel*2 +: 2],
                link_dest_use[link_sel] ? link_dest[link_sel*8 +: 8] : 8'h00,
                cfg.dir[link_sel],
                cfg.net[link_sel],
                link_junk[link_sel],
                link_dest_use[link_sel],
                link_src_use[link_sel]);
        end
    end

    //------------------------------------------------------------------------
    // Write strobes
    //------------------------------------------------------------------------
    // Writes act in the setup cycle; full words only, since fields span lanes.
    assign cfg.wr_link = setup_now && pwrite && hit_link && (pstrb == 4'hf);
    assign cfg.wr_origin = setup_now && pwrite && hit_origin && (pstrb == 4'hf);
    assign cfg.wr_sel = link_sel;
    assign cfg.wr_data = pwdata;

    //------------------------------------------------------------------------
    // APB phase machine
    //------------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.ready = 1'b0;
        case (state_reg.phase)
            lsdr_pkg::LSDR_IDLE: begin
                if (setup_now) begin
                    state_next.phase = lsdr_pkg::LSDR_ACCESS;
                    state_next.rdata = pwrite ? 32'h0000_0000 : read_word;
                    state_next.err = !(hit_origin || hit_link);
                    state_next.ready = 1'b1;
                end
            end
            lsdr_pkg::LSDR_ACCESS: begin
                state_next.phase = lsdr_pkg::LSDR_IDLE;
                state_next.err = 1'b0;
            end
            default: begin
                state_next.phase = lsdr_pkg::LSDR_IDLE;
            end
        endcase
        if (!rst_n) begin
            state_next.phase = lsdr_pkg::LSDR_IDLE;
            state_next.rdata = 32'h0000_0000;
            state_next.ready = 1'b0;
            state_next.err = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        state_reg <= state_next;
    end

    assign prdata = state_reg.rdata;
    assign pready = state_reg.ready;
    assign pslverr = state_reg.err;

    lsdr_cfg_core u_core (
        .clock(clock),
        .rst_n(rst_n),
        .dbg_event(dbg_event),
        .dbg_cause(dbg_cause),
        .cfg(cfg)
    );

    //------------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------------
    a_ready_once: assert property (@(posedge clock) disable iff (!rst_n)
        setup_now |=> pready ##1 !pready)
        else $error("pready not a single cycle answer");
    a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
        pready |-> (prdata & 32'hfc00_f0c8) == 32'h0000_0000)
        else $error("reserved bits read nonzero");
    a_src_type: assert property (@(posedge clock) disable iff (!rst_n)
        setup_now && !pwrite && hit_link |=>
        prdata[25:24] == $past(link_src_type[link_sel*2 +: 2]))
        else $error("source type mismatch");
    a_dest_num: assert property (@(posedge clock) disable iff (!rst_n)
        setup_now && !pwrite && hit_link && link_dest_use[link_sel] |=>
        prdata[23:16] == $past(link_dest[link_sel*8 +: 8]))
        else $error("destination number mismatch");
    a_junk_flag: assert property (@(posedge clock) disable iff (!rst_n)
        setup_now && !pwrite && hit_link |=> prdata[2] == $past(link_junk[link_sel]))
        else $error("junk flag mismatch");
    a_dest_use: assert property (@(posedge clock) disable iff (!rst_n)
        setup_now && !pwrite && hit_link |=> prdata[1] == $past(link_dest_use[link_sel]))
        else $error("dest in use mismatch");
    a_src_use: assert property (@(posedge clock) disable iff (!rst_n)
        setup_now && !pwrite && hit_link |=> prdata[0] == $past(link_src_use[link_sel]))
        else $error("source in use mismatch");
    a_origin_read: assert property (@(posedge clock) disable iff (!rst_n)
        setup_now && !pwrite && hit_origin |=>
        prdata[4] == $past(cfg.origin[2]) && prdata[1:0] == $past(cfg.origin[1:0]))
        else $error("origin read mismatch");
endmodule : lsdr_link_status_regs

// file: rtl/lsdr_pkg.sv
// Package of constants and types for the link status and debug register bank.
//----------------------------------------------------------------------------
//----------------------------------------------------------------------------
package lsdr_pkg;
    localparam int NUM_LINKS = 8;
    localparam logic [7:0] IDX_DEBUG_ORIGIN = 8'h1f;
    localparam logic [7:0] IDX_LINK_BASE = 8'h20;
    localparam int ORIGIN_PIN_BIT = 4;
    localparam int ORIGIN_CORE1_BIT = 1;
    localparam int ORIGIN_CORE0_BIT = 0;
    localparam int SRC_TYPE_LSB = 24;
    localparam int DEST_LSB = 16;
    localparam int DIR_LSB = 8;
    localparam int NET_LSB = 4;
    localparam int JUNK_BIT = 2;
    localparam int DEST_USE_BIT = 1;
    localparam int SRC_USE_BIT = 0;
    localparam logic [3:0] DIR_RESET = 4'h0;
    localparam logic [1:0] NET_RESET = 2'h0;
    localparam logic [2:0] ORIGIN_RESET = 3'h0;
    localparam logic [1:0] serial_link_kind = 2'h0;
    localparam logic [1:0] processor_link_kind = 2'h1;
    localparam logic [1:0] switch_control_kind = 2'h2;

    typedef enum logic [1:0] {
        LSDR_IDLE = 2'b00,
        LSDR_ACCESS = 2'b01,
        LSDR_DONE = 2'b11
    } lsdr_phase_t;

    function automatic logic [31:0] lsdr_link_word(
        input logic [1:0] src_type,
        input logic [7:0] dest,
        input logic [3:0] dir,
        input logic [1:0] net,
        input logic junk,
        input logic dest_use,
        input logic src_use
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        w[SRC_TYPE_LSB +: 2] = src_type;
        w[DEST_LSB +: 8] = dest;
        w[DIR_LSB +: 4] = dir;
        w[NET_LSB +: 2] = net;
        w[JUNK_BIT] = junk;
        w[DEST_USE_BIT] = dest_use;
        w[SRC_USE_BIT] = src_use;
        return w;
    endfunction : lsdr_link_word
endpackage : lsdr_pkg

// file: sim/lsdr_link_status_regs_tb.sv
// Self-checking bench for the link status and debug register bank.
`timescale 1ns/1ps
module lsdr_link_status_regs_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic dbg_event = 1'b0;
    logic [2:0] dbg_cause = 3'h0;
    logic [15:0] link_src_type = 16'h0;
    logic [63:0] link_dest = 64'h0;
    logic [7:0] link_junk = 8'h0;
    logic [7:0] link_dest_use = 8'h0;
    logic [7:0] link_src_use = 8'h0;
    int mismatches = 0;
    int checked = 0;
    logic [32:0] notes [$];
    logic [3:0] dir_m [8];
    logic [1:0] net_m [8];
    logic [31:0] wd;

    always #5 clock = ~clock;

    lsdr_link_status_regs i_lsdr_link_status_regs (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dbg_event(dbg_event),
        .dbg_cause(dbg_cause), .link_src_type(link_src_type), .link_dest(link_dest),
        .link_junk(link_junk), .link_dest_use(link_dest_use), .link_src_use(link_src_use));

    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic results();
        if (mismatches == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results

    // The answer is judged mid-cycle, after the registered outputs have settled.
    always @(negedge clock) begin
        if (pready === 1'b1) begin
            if (notes.size() == 0) check("spare pready", 33'h1, 33'h0);
            else check("pslverr prdata", {pslverr, prdata}, notes.pop_front());
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [32:0] exp);
        int n;
        notes.push_back(exp);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) mismatches++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [11:0] la(input int n);
        return 12'h080 + 12'(4 * n);
    endfunction : la

    function automatic logic [32:0] link_exp(input int n);
        logic [7:0] d;
        d = (link_dest_use[n] === 1'b1) ? link_dest[8*n +: 8] : 8'h00;
        return {7'h00, link_src_type[2*n +: 2], d, 4'h0, dir_m[n], 2'h0, net_m[n], 1'b0,
            link_junk[n], link_dest_use[n], link_src_use[n]};
    endfunction : link_exp

    initial begin
        void'($urandom(37482));
        for (int n = 0; n < 8; n++) begin
            dir_m[n] = 4'h0;
            net_m[n] = 2'h0;
        end
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        apb(1'b0, 12'h07c, 32'h0, 4'h0, 33'h0);
        for (int n = 0; n < 8; n++) apb(1'b0, la(n), 32'h0, 4'h0, link_exp(n));
        for (int r = 0; r < 3; r++) begin
            for (int n = 0; n < 8; n++) link_src_type[2*n +: 2] <= 2'((n + r) % 3);
            link_dest <= {$urandom, $urandom};
            link_junk <= 8'($urandom);
            link_dest_use <= 8'($urandom);
            link_src_use <= 8'($urandom);
            for (int n = 0; n < 8; n++) begin
                wd = $urandom;
                apb(1'b1, la(n), wd, 4'hf, 33'h0);
                dir_m[n] = wd[11:8];
                net_m[n] = wd[5:4];
                apb(1'b0, la(n), 32'h0, 4'h0, link_exp(n));
                // A partial strobe must leave the word alone.
                apb(1'b1, la(n), ~wd, 4'h7, 33'h0);
                apb(1'b0, la(n), 32'h0, 4'h0, link_exp(n));
            end
        end
        apb(1'b1, 12'h0a0, 32'hffff_ffff, 4'hf, {1'b1, 32'h0});
        apb(1'b0, 12'h0a0, 32'h0, 4'h0, {1'b1, 32'h0});
        for (int c = 1; c < 8; c++) begin
            dbg_cause <= 3'(c);
            dbg_event <= 1'b1;
            @(posedge clock);
            dbg_event <= 1'b0;
            dbg_cause <= ~3'(c);
            apb(1'b0, 12'h07c, 32'h0, 4'h0, {28'h0, c[2], 2'b00, c[1], c[0]});
        end
        apb(1'b1, 12'h07c, 32'hffff_ffff, 4'hf, 33'h0);
        apb(1'b0, 12'h07c, 32'h0, 4'h0, 33'h13);
        // A second reset must bring the writable fields back to zero.
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        dir_m[3] = 4'h0;
        net_m[3] = 2'h0;
        apb(1'b0, la(3), 32'h0, 4'h0, link_exp(3));
        repeat (3) @(posedge clock);
        check("notes left", 33'(notes.size()), 33'h0);
        results();
    end

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        results();
    end
endmodule : lsdr_link_status_regs_tb
